// *** src/uart_ext_consts.svh ***
// register offsets, field positions and reset values of the extended channel block
`ifndef UART_EXT_CONSTS_SVH
`define UART_EXT_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_SPECIAL_FUNC 6'h07
`define IDX_ENH_FEATURE 6'h09
`define IDX_ADV_FLOW 6'h0f
`define IDX_TX_THRESH 6'h10
`define IDX_RX_THRESH 6'h11
`define IDX_FLOW_LOW 6'h12
`define IDX_FLOW_HIGH 6'h13
`define IDX_PRESCALE 6'h14
`define IDX_FIFO_COUNT 6'h15
`define IDX_TXCNT_OVS 6'h16
`define IDX_LINE_SUMMARY 6'h17

// field positions
`define SFR_RXCNT_SEL 6
`define SFR_TXCNT_SEL 7
`define EFR_ENHANCED 4
`define EFR_AUTO_RTS 6

// reset values
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_WORD 32'h0000_0000
`endif

// *** src/uart_ext_pkg.sv ***
// types of the extended channel register block
package uart_ext_pkg;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_phase_t;

    typedef struct packed {
        bus_phase_t phase;
        logic [31:0] rdata;
        logic [7:0] special_function_select;
        logic [7:0] enhanced_feature_control;
        logic [7:0] tx_trigger_level;
        logic [7:0] rx_trigger_level;
        logic [7:0] flow_low_level;
        logic [7:0] flow_high_level;
        logic [7:0] prescale;
        logic [3:0] oversample_value;
        logic xon_xoff_detect;
        logic sw_paused;
        logic tx_irq;
        logic rx_irq;
    } ext_state_t;

    typedef struct packed {
        logic hold;
    } hyst_state_t;
endpackage

// *** src/flow_hysteresis.sv ***
// level comparator with hysteresis that drives the automatic RTS line
`timescale 1ns/100ps
`include "uart_ext_consts.svh"
module flow_hysteresis #(
    parameter int WIDTH = 8
) (
    // clock and control
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic enable_i,
    // levels
    input wire logic [WIDTH-1:0] level_i,
    input wire logic [WIDTH-1:0] high_i,
    input wire logic [WIDTH-1:0] low_i,
    // result, high means pause the remote
    output logic hold_o
);
    uart_ext_pkg::hyst_state_t q;
    uart_ext_pkg::hyst_state_t next_q;

    always_comb begin
        next_q = q;
        if (!enable_i) begin
            next_q.hold = 1'b0;
        end else if (level_i >= high_i) begin
            next_q.hold = 1'b1;
        end else if (level_i < low_i) begin
            next_q.hold = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign hold_o = q.hold;
endmodule // flow_hysteresis

// *** src/uart_ext_regs.sv ***
// extended control and status registers of one serial channel
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "uart_ext_consts.svh"
module uart_ext_regs (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // transmitter events and state
    input wire logic tx_remote_halt_i,
    input wire logic tx_xoff_sent_i,
    input wire logic tx_xon_sent_i,
    input wire logic tx_holding_empty_i,
    input wire logic tx_shift_empty_i,
    // receiver events and state
    input wire logic rx_xon_char_i,
    input wire logic rx_xoff_char_i,
    input wire logic rx_overrun_i,
    input wire logic rx_parity_err_i,
    input wire logic rx_frame_err_i,
    input wire logic rx_break_i,
    input wire logic rx_fifo_err_i,
    input wire logic special_char_irq_en_i,
    // fifo fill levels
    input wire logic [7:0] rx_fifo_level_i,
    input wire logic [7:0] tx_fifo_level_i,
    input wire logic [7:0] line_status_entry_i,
    // outputs to the channel
    output logic rts_n_o,
    output logic xoff_irq_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic [3:0] prescale_n_term_o,
    output logic [3:0] prescale_m_term_o,
    output logic [3:0] oversample_value_o
);
    uart_ext_pkg::ext_state_t q;
    uart_ext_pkg::ext_state_t next_q;
    logic [5:0] idx;
    logic req;
    logic fire;
    logic adv_read;
    logic [7:0] adv_flow_status;
    logic [7:0] line_summary;
    logic [7:0] rd_byte;
    logic auto_rts_en;
    logic rts_hold;

    assign idx = avs_address_i[7:2];
    assign req = avs_read_i || avs_write_i;
    // the answer is given one cycle after the request is seen
    assign avs_waitrequest_o = req && (q.phase != uart_ext_pkg::BUS_ANSWER);
    assign fire = ce_i && req && (q.phase == uart_ext_pkg::BUS_ANSWER);
    assign adv_read = fire && avs_read_i && (idx == `IDX_ADV_FLOW);

    assign auto_rts_en = q.enhanced_feature_control[`EFR_ENHANCED] &&
        q.enhanced_feature_control[`EFR_AUTO_RTS];

    flow_hysteresis #(
        .WIDTH(8)
    ) u_rts_hyst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .enable_i(auto_rts_en),
        .level_i(rx_fifo_level_i),
        .high_i(q.flow_high_level),
        .low_i(q.flow_low_level),
        .hold_o(rts_hold)
    );

    always_comb begin
        adv_flow_status = 8'h00;
        adv_flow_status[0] = tx_remote_halt_i;
        adv_flow_status[1] = q.sw_paused || rts_hold;
        adv_flow_status[2] = q.xon_xoff_detect;
    end

    // live view, nothing here is cleared by the read
    always_comb begin
        line_summary[0] = rx_fifo_level_i != 8'h00;
        line_summary[1] = rx_overrun_i;
        line_summary[2] = rx_parity_err_i;
        line_summary[3] = rx_frame_err_i;
        line_summary[4] = rx_break_i;
        line_summary[5] = tx_holding_empty_i;
        line_summary[6] = tx_shift_empty_i;
        line_summary[7] = rx_fifo_err_i;
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            `IDX_SPECIAL_FUNC: rd_byte = q.special_function_select;
            `IDX_ENH_FEATURE: rd_byte = q.enhanced_feature_control;
            `IDX_ADV_FLOW: rd_byte = adv_flow_status;
            `IDX_TX_THRESH: rd_byte = q.tx_trigger_level;
            `IDX_RX_THRESH: rd_byte = q.rx_trigger_level;
            `IDX_FLOW_LOW: rd_byte = q.flow_low_level;
            `IDX_FLOW_HIGH: rd_byte = q.flow_high_level;
            `IDX_PRESCALE: rd_byte = q.prescale;
            `IDX_FIFO_COUNT: begin
                if (q.special_function_select[`SFR_RXCNT_SEL]) begin
                    rd_byte = rx_fifo_level_i;
                end else begin
                    rd_byte = line_status_entry_i;
                end
            end
            `IDX_TXCNT_OVS: begin
                if (q.special_function_select[`SFR_TXCNT_SEL]) begin
                    rd_byte = tx_fifo_level_i;
                end else begin
                    rd_byte = {4'h0, q.oversample_value};
                end
            end
            `IDX_LINE_SUMMARY: rd_byte = line_summary;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_q = q;
        // bus handshake
        unique case (q.phase)
            uart_ext_pkg::BUS_IDLE: begin
                if (req) begin
                    next_q.phase = uart_ext_pkg::BUS_ANSWER;
                    next_q.rdata = avs_read_i ? {24'h000000, rd_byte} : `RST_WORD;
                end
            end
            uart_ext_pkg::BUS_ANSWER: begin
                next_q.phase = uart_ext_pkg::BUS_IDLE;
            end
        endcase
        // register writes, lane 0 only
        if (fire && avs_write_i && avs_byteenable_i[0]) begin
            unique case (idx)
                `IDX_SPECIAL_FUNC: next_q.special_function_select = avs_writedata_i[7:0];
                `IDX_ENH_FEATURE: next_q.enhanced_feature_control = avs_writedata_i[7:0];
                `IDX_TX_THRESH: next_q.tx_trigger_level = avs_writedata_i[7:0];
                `IDX_RX_THRESH: next_q.rx_trigger_level = avs_writedata_i[7:0];
                `IDX_FLOW_LOW: next_q.flow_low_level = avs_writedata_i[7:0];
                `IDX_FLOW_HIGH: next_q.flow_high_level = avs_writedata_i[7:0];
                `IDX_PRESCALE: next_q.prescale = avs_writedata_i[7:0];
                `IDX_TXCNT_OVS: begin
                    if (!q.special_function_select[`SFR_TXCNT_SEL]) begin
                        next_q.oversample_value = avs_writedata_i[3:0];
                    end
                end
                default: next_q.phase = uart_ext_pkg::BUS_IDLE;
            endcase
        end
        // detect flag: a read clears only what it returned, a new character wins
        if (adv_read && q.rdata[2]) begin
            next_q.xon_xoff_detect = 1'b0;
        end
        if (rx_xon_char_i || rx_xoff_char_i) begin
            next_q.xon_xoff_detect = 1'b1;
        end
        // in-band pause state of the remote transmitter
        if (tx_xon_sent_i) begin
            next_q.sw_paused = 1'b0;
        end
        if (tx_xoff_sent_i) begin
            next_q.sw_paused = 1'b1;
        end
        // fifo level interrupts
        next_q.rx_irq = rx_fifo_level_i >= q.rx_trigger_level;
        next_q.tx_irq = tx_fifo_level_i <= q.tx_trigger_level;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q.phase <= uart_ext_pkg::BUS_IDLE;
            q.rdata <= `RST_WORD;
            q.special_function_select <= `RST_BYTE;
            q.enhanced_feature_control <= `RST_BYTE;
            q.tx_trigger_level <= `RST_BYTE;
            q.rx_trigger_level <= `RST_BYTE;
            q.flow_low_level <= `RST_BYTE;
            q.flow_high_level <= `RST_BYTE;
            q.prescale <= `RST_BYTE;
            q.oversample_value <= `RST_NIBBLE;
            q.xon_xoff_detect <= 1'b0;
            q.sw_paused <= 1'b0;
            q.tx_irq <= 1'b0;
            q.rx_irq <= 1'b0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign rts_n_o = rts_hold;
    assign xoff_irq_o = q.xon_xoff_detect && special_char_irq_en_i;
    assign tx_irq_o = q.tx_irq;
    assign rx_irq_o = q.rx_irq;
    assign prescale_n_term_o = q.prescale[3:0];
    assign prescale_m_term_o = q.prescale[7:4];
    assign oversample_value_o = q.oversample_value;

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_request_waits;
        ce_i && req && avs_waitrequest_o;
    endsequence

    sequence s_answer;
        !avs_waitrequest_o;
    endsequence

    sequence s_detect_event;
        ce_i && (rx_xon_char_i || rx_xoff_char_i);
    endsequence

    a_bus_answer_one: assert property (
        s_request_waits ##1 (req && ce_i) |-> s_answer
    ) else $error("register access not answered one cycle after request");

    a_detect_sets: assert property (
        s_detect_event |=> adv_flow_status[2] ##0 (xoff_irq_o == special_char_irq_en_i)
    ) else $error("character arrival did not set the detect bit");

    a_read_clears: assert property (
        adv_read && q.rdata[2] && !rx_xon_char_i && !rx_xoff_char_i |=> !q.xon_xoff_detect
    ) else $error("advanced status read did not clear the detect bit");

    a_detect_readback: assert property (
        fire && avs_read_i && idx == `IDX_ADV_FLOW |-> avs_readdata_o[2] == $past(q.xon_xoff_detect)
    ) else $error("advanced status read returned stale detect value");

    a_level_six: assert property (
        xoff_irq_o |-> q.xon_xoff_detect && special_char_irq_en_i
    ) else $error("level six interrupt without enabled detect");

    a_rx_irq_level: assert property (
        ce_i ##1 rx_irq_o |-> $past(rx_fifo_level_i) >= $past(q.rx_trigger_level)
    ) else $error("receive interrupt above level without cause");

    a_tx_irq_level: assert property (
        ce_i && tx_fifo_level_i > q.tx_trigger_level |=> !tx_irq_o
    ) else $error("transmit interrupt raised with level above trigger");

    a_rts_pause: assert property (
        ce_i && auto_rts_en && rx_fifo_level_i >= q.flow_high_level |=> rts_n_o
    ) else $error("rts not deasserted at high threshold");

    a_rts_resume: assert property (
        ce_i && rx_fifo_level_i < q.flow_low_level && rx_fifo_level_i < q.flow_high_level
        |=> !rts_n_o
    ) else $error("rts not released below low threshold");

    a_thresh_write: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_TX_THRESH
        |=> q.tx_trigger_level == $past(avs_writedata_i[7:0])
    ) else $error("transmit trigger level write lost");

    a_summary_live: assert property (
        fire && avs_read_i && idx == `IDX_LINE_SUMMARY |-> avs_readdata_o[7:0] == $past(line_summary)
    ) else $error("summary read does not match line state");

    a_ovs_upper_zero: assert property (
        fire && avs_read_i && idx == `IDX_TXCNT_OVS && !q.special_function_select[`SFR_TXCNT_SEL]
        |-> avs_readdata_o[7:4] == 4'h0
    ) else $error("oversample register upper bits not zero");

    a_prescale_fields: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_PRESCALE
        |=> prescale_m_term_o == $past(avs_writedata_i[7:4])
    ) else $error("prescaler m term does not follow write");

    a_prescale_n: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_PRESCALE
        |=> prescale_n_term_o == $past(avs_writedata_i[3:0])
    ) else $error("prescaler n term does not follow write");

    a_rx_thresh_write: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_RX_THRESH
        |=> q.rx_trigger_level == $past(avs_writedata_i[7:0])
    ) else $error("receive trigger level write lost");

    a_low_write: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_FLOW_LOW
        |=> q.flow_low_level == $past(avs_writedata_i[7:0])
    ) else $error("flow low threshold write lost");

    a_high_write: assert property (
        fire && avs_write_i && avs_byteenable_i[0] && idx == `IDX_FLOW_HIGH
        |=> q.flow_high_level == $past(avs_writedata_i[7:0])
    ) else $error("flow high threshold write lost");

    a_halt_readback: assert property (
        fire && avs_read_i && idx == `IDX_ADV_FLOW |-> avs_readdata_o[0] == $past(tx_remote_halt_i)
    ) else $error("terminate status read does not match transmitter state");

    a_xoff_pause: assert property (
        ce_i && tx_xoff_sent_i |=> adv_flow_status[1]
    ) else $error("remote disable bit not set after xoff sent");

    a_xon_resume: assert property (
        ce_i && tx_xon_sent_i && !tx_xoff_sent_i |=> adv_flow_status[1] == rts_n_o
    ) else $error("remote disable bit not cleared after xon sent");

    a_rxcnt_read: assert property (
        fire && avs_read_i && idx == `IDX_FIFO_COUNT && q.special_function_select[`SFR_RXCNT_SEL]
        |-> avs_readdata_o == {24'h000000, $past(rx_fifo_level_i)}
    ) else $error("receive count read mismatch");

    a_lscnt_read: assert property (
        fire && avs_read_i && idx == `IDX_FIFO_COUNT && !q.special_function_select[`SFR_RXCNT_SEL]
        |-> avs_readdata_o == {24'h000000, $past(line_status_entry_i)}
    ) else $error("line status count read mismatch");

    a_txcnt_read: assert property (
        fire && avs_read_i && idx == `IDX_TXCNT_OVS && q.special_function_select[`SFR_TXCNT_SEL]
        |-> avs_readdata_o == {24'h000000, $past(tx_fifo_level_i)}
    ) else $error("transmit count read mismatch");

    a_txcnt_ro: assert property (
        fire && avs_write_i && idx == `IDX_TXCNT_OVS && q.special_function_select[`SFR_TXCNT_SEL]
        |=> $stable(q.oversample_value)
    ) else $error("write through transmit count changed oversample value");

    a_rx_avail_read: assert property (
        fire && avs_read_i && idx == `IDX_LINE_SUMMARY
        |-> avs_readdata_o[0] == ($past(rx_fifo_level_i) != 8'h00)
    ) else $error("data available bit does not match receive level");

    a_read_upper_zero: assert property (
        fire && avs_read_i |-> avs_readdata_o[31:8] == 24'h000000
    ) else $error("read data upper lanes not zero");
endmodule // uart_ext_regs

// *** sim/remote_peer.sv ***
// behavioural remote serial device: fills the receive fifo and sends flow characters
`timescale 1ns/100ps
module remote_peer (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // flow control from the channel
    input wire logic rts_n_i,
    // bench commands
    input wire logic fill_i,
    input wire logic drain_i,
    input wire logic xon_req_i,
    input wire logic xoff_req_i,
    // what the channel sees
    output logic [7:0] rx_level_o,
    output logic xon_char_o,
    output logic xoff_char_o
);
    logic [1:0] gap;

    // one character every four cycles, and only while the channel lets us send
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rx_level_o <= 8'h00;
            gap <= 2'h0;
            xon_char_o <= 1'b0;
            xoff_char_o <= 1'b0;
        end else begin
            gap <= gap + 2'h1;
            xon_char_o <= xon_req_i;
            xoff_char_o <= xoff_req_i;
            if (drain_i && rx_level_o != 8'h00) begin
                rx_level_o <= rx_level_o - 8'h01;
            end else if (fill_i && !rts_n_i && gap == 2'h3) begin
                rx_level_o <= rx_level_o + 8'h01;
            end
        end
    end
endmodule // remote_peer

// *** sim/uart_extended_status_control_tb_top.sv ***
// self-checking bench for the extended channel register block
`timescale 1ns/100ps
module uart_extended_status_control_tb_top;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] be = 4'h1;
    logic [31:0] wdata = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] st = 8'h00;
    logic halt = 1'b0;
    logic xoff_sent = 1'b0;
    logic xon_sent = 1'b0;
    logic irq_en = 1'b0;
    logic [7:0] tx_level = 8'h00;
    logic [7:0] ls_count = 8'h00;
    logic fill = 1'b0;
    logic drain = 1'b0;
    logic xon_req = 1'b0;
    logic xoff_req = 1'b0;
    logic xon_ch, xoff_ch, rts_n, xoff_irq, tx_irq, rx_irq;
    logic [7:0] rx_level;
    logic [3:0] n_term, m_term, ovs;
    logic [31:0] rd;
    int err_count = 0;
    int n_tests = 0;

    initial forever #50 core_clk_i = ~core_clk_i;

    uart_ext_regs uut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .tx_remote_halt_i(halt),
        .tx_xoff_sent_i(xoff_sent), .tx_xon_sent_i(xon_sent), .tx_holding_empty_i(st[5]),
        .tx_shift_empty_i(st[6]), .rx_xon_char_i(xon_ch), .rx_xoff_char_i(xoff_ch),
        .rx_overrun_i(st[1]), .rx_parity_err_i(st[2]), .rx_frame_err_i(st[3]),
        .rx_break_i(st[4]), .rx_fifo_err_i(st[7]), .special_char_irq_en_i(irq_en),
        .rx_fifo_level_i(rx_level), .tx_fifo_level_i(tx_level),
        .line_status_entry_i(ls_count), .rts_n_o(rts_n), .xoff_irq_o(xoff_irq),
        .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .prescale_n_term_o(n_term),
        .prescale_m_term_o(m_term), .oversample_value_o(ovs)
    );

    remote_peer peer (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rts_n_i(rts_n), .fill_i(fill),
        .drain_i(drain), .xon_req_i(xon_req), .xoff_req_i(xoff_req),
        .rx_level_o(rx_level), .xon_char_o(xon_ch), .xoff_char_o(xoff_ch)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // request held until waitrequest is sampled low at a rising edge; that edge completes it
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i <= a;
        wdata <= d;
        avs_write_i <= we;
        avs_read_i <= !we;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        check("bus answer", 32'(n < 40), 32'h1);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 5; i++) begin
            rdchk("rw reset", 8'h40 + 8'(4 * i), 32'h0);
        end
        rdchk("adv reset", 8'h3c, 32'h0);
        rdchk("ovs reset", 8'h58, 32'h0);
        rdchk("unmapped", 8'hfc, 32'h0);
    endtask

    task automatic t_rw;
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h40 + 8'(4 * i), 32'(8'h5a ^ 8'(i * 17)));
            rdchk("rw back", 8'h40 + 8'(4 * i), 32'(8'h5a ^ 8'(i * 17)));
        end
        be <= 4'he;
        bus(1'b1, 8'h40, 32'hff);
        be <= 4'h1;
        rdchk("lane ignored", 8'h40, 32'h5a);
        bus(1'b1, 8'h50, 32'h2b);
        cyc(2);
        check("n term", 32'(n_term), 32'hb);
        check("m term", 32'(m_term), 32'h2);
        bus(1'b1, 8'h3c, 32'hff);
        rdchk("adv read only", 8'h3c, 32'h0);
    endtask

    task automatic t_detect;
        for (int k = 0; k < 2; k++) begin
            irq_en <= k[0];
            if (k == 0) xon_req <= 1'b1;
            else xoff_req <= 1'b1;
            cyc(1);
            xon_req <= 1'b0;
            xoff_req <= 1'b0;
            cyc(3);
            check("xoff irq", 32'(xoff_irq), 32'(k));
            rdchk("detect set", 8'h3c, 32'h4);
            rdchk("detect clr", 8'h3c, 32'h0);
            check("xoff irq off", 32'(xoff_irq), 32'h0);
        end
    endtask

    task automatic t_status;
        halt <= 1'b1;
        cyc(2);
        rdchk("halt", 8'h3c, 32'h1);
        halt <= 1'b0;
        xoff_sent <= 1'b1;
        cyc(1);
        xoff_sent <= 1'b0;
        cyc(2);
        rdchk("tx disable", 8'h3c, 32'h2);
        xon_sent <= 1'b1;
        cyc(1);
        xon_sent <= 1'b0;
        cyc(2);
        rdchk("tx enable", 8'h3c, 32'h0);
    endtask

    task automatic t_summary;
        for (int k = 1; k < 8; k++) begin
            st <= 8'(1 << k);
            cyc(1);
            rdchk("summary", 8'h5c, 32'(1 << k));
            rdchk("summary live", 8'h5c, 32'(1 << k));
        end
        st <= 8'h00;
    endtask

    task automatic t_flow;
        int n;
        bus(1'b1, 8'h48, 32'h02);
        bus(1'b1, 8'h4c, 32'h05);
        bus(1'b1, 8'h24, 32'h50);
        fill <= 1'b1;
        n = 0;
        while (rts_n !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        cyc(12);
        check("paused at high", 32'(rx_level), 32'h5);
        check("rts high", 32'(rts_n), 32'h1);
        rdchk("rts disable", 8'h3c, 32'h2);
        rdchk("data avail", 8'h5c, 32'h1);
        fill <= 1'b0;
        drain <= 1'b1;
        cyc(3);
        drain <= 1'b0;
        cyc(3);
        check("held at low", 32'(rts_n), 32'h1);
        drain <= 1'b1;
        cyc(1);
        drain <= 1'b0;
        cyc(3);
        check("resumed", 32'(rts_n), 32'h0);
    endtask

    task automatic t_counts;
        ls_count <= 8'h07;
        tx_level <= 8'h09;
        bus(1'b1, 8'h1c, 32'h40);
        rdchk("rx count", 8'h54, 32'h1);
        bus(1'b1, 8'h1c, 32'h00);
        rdchk("ls count", 8'h54, 32'h7);
        bus(1'b1, 8'h58, 32'hff);
        rdchk("oversample", 8'h58, 32'hf);
        check("ovs out", 32'(ovs), 32'hf);
        bus(1'b1, 8'h1c, 32'h80);
        bus(1'b1, 8'h58, 32'h03);
        rdchk("tx count", 8'h58, 32'h9);
        bus(1'b1, 8'h1c, 32'h00);
        rdchk("ovs kept", 8'h58, 32'hf);
    endtask

    task automatic t_irq;
        tx_level <= 8'h04;
        bus(1'b1, 8'h40, 32'h03);
        cyc(2);
        check("tx irq off", 32'(tx_irq), 32'h0);
        bus(1'b1, 8'h40, 32'h04);
        cyc(2);
        check("tx irq on", 32'(tx_irq), 32'h1);
        bus(1'b1, 8'h44, 32'h02);
        cyc(2);
        check("rx irq off", 32'(rx_irq), 32'h0);
        bus(1'b1, 8'h44, 32'h01);
        cyc(2);
        check("rx irq on", 32'(rx_irq), 32'h1);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset;
        t_rw;
        t_detect;
        t_status;
        t_summary;
        t_flow;
        t_counts;
        t_irq;
        summarize;
    end

    // the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        summarize;
    end
endmodule // uart_extended_status_control_tb_top
